/* inc/cmbc_pkg.sv */
// package: register map, field positions and constants of the can message buffer control block
package cmbc_pkg;
	// register addresses (byte-wide registers on the plain port)
	localparam logic [7:0] ADDR_MODE = 8'h00; // functional mode, loopback, wake filter, config
	localparam logic [7:0] ADDR_DIR_SEL = 8'h01; // buffer direction select, one bit per configurable buffer
	localparam logic [7:0] ADDR_STATUS = 8'h02; // mode and activity status
	localparam logic [7:0] ADDR_FILT_SEL = 8'h03; // filter index for the filter window
	localparam logic [7:0] ADDR_FILT_ID0 = 8'h04; // filter id bits 7..0
	localparam logic [7:0] ADDR_FILT_ID1 = 8'h05; // filter id bits 15..8
	localparam logic [7:0] ADDR_FILT_ID2 = 8'h06; // filter id bits 23..16
	localparam logic [7:0] ADDR_FILT_ID3 = 8'h07; // filter id bits 28..24 and ext flag
	localparam logic [7:0] ADDR_FILT_LINK = 8'h08; // mask link of selected filter, enable
	localparam logic [7:0] ADDR_MASK_SEL = 8'h09; // mask index for the mask window
	localparam logic [7:0] ADDR_MASK_ID0 = 8'h0A; // mask bits 7..0
	localparam logic [7:0] ADDR_MASK_ID1 = 8'h0B; // mask bits 15..8
	localparam logic [7:0] ADDR_MASK_ID2 = 8'h0C; // mask bits 23..16
	localparam logic [7:0] ADDR_MASK_ID3 = 8'h0D; // mask bits 28..24
	localparam logic [7:0] ADDR_RX_SIDL = 8'h10; // rx_std_id_low, +2 per receive buffer
	localparam logic [7:0] ADDR_RX_EIDH = 8'h14; // rx_ext_id_high, +2 per receive buffer
	localparam logic [7:0] ADDR_RX_EIDL = 8'h18; // rx_ext_id_low, +2 per receive buffer
	localparam logic [7:0] ADDR_BUF_CON = 8'h20; // buffer_tx_control 0..8 (0..2 dedicated)
	localparam logic [7:0] ADDR_ERR = 8'h30; // error state flags, write one to clear
	// widths and counts
	localparam int NUM_BUF = 9; // three dedicated plus six configurable
	localparam int NUM_CFG = 6; // configurable buffers
	localparam int NUM_DED = 3; // dedicated transmit buffers
	localparam int NUM_FILT = 16; // acceptance filters
	localparam int NUM_MASK = 4; // masks 0,1 full, 2 = filter 15, 3 = accept all
	localparam int NUM_RXB = 2; // prioritised receive buffers
	localparam int ID_W = 29; // full identifier width
	localparam logic [1:0] MASK_FILT15 = 2'h2; // mask slot that uses filter 15 as mask
	localparam logic [3:0] FILT_AS_MASK = 4'hF; // filter that may act as a mask
	// buffer control field positions
	localparam int BC_DONE = 7; // tx_done_flag
	localparam int BC_ABT = 6; // tx_aborted_status
	localparam int BC_LARB = 5; // tx_lost_arb_status
	localparam int BC_ERR = 4; // tx_bus_error_status
	localparam int BC_REQ = 3; // tx_request
	localparam int BC_RTR = 2; // auto_remote_reply_en
	// rx_std_id_low positions
	localparam int SIDL_SRR = 4; // substitute_remote_req
	localparam int SIDL_EXT = 3; // extended_frame_flag
	// mode register fields
	localparam int MODE_LSB = 0; // functional mode bits 1..0
	localparam int MODE_CFG = 4; // configuration request
	localparam int MODE_LOOP = 5; // loopback
	localparam int MODE_WFILT = 6; // wake low-pass filter enable
	localparam int MODE_SLEEP = 7; // sleep request
	localparam logic [1:0] FMODE_LEGACY = 2'h0; // legacy mode
	localparam logic [1:0] FMODE_ENH = 2'h1; // enhanced legacy mode
	localparam logic [1:0] FMODE_FIFO = 2'h2; // fifo mode
	localparam logic [7:0] MODE_RESET = 8'h10; // configuration mode after reset
	localparam logic [3:0] WAKE_FILT_LEN = 4'h7; // count reached when filtered: wake on the eighth dominant sample
	localparam logic [7:0] DATA_ZERO = 8'h00; // read value of unmapped addresses
	// protocol engine event codes
	typedef enum {TXR_NONE, TXR_OK, TXR_LARB, TXR_ERR} cmbc_txres_t;
endpackage

/* src/cmbc_core.sv */
// core: registers, acceptance filtering, receive storage and transmit buffer control
//
// Overview of operation
// - three functional modes: legacy, enhanced, fifo
// - zero to eight bytes, standard and extended
// - sixteen filters, each linked to one of four masks
// - two full masks assignable to any filter
// - one filter may serve as a mask
// - three dedicated tx buffers, priority, abortable
// - six buffers selectable receive or transmit
// - error-checked matching frames stored in two buffers
// - extended id bytes shown read-only
// - transmit layout when buffer enable bit set
// - priority 11 highest, identifier untouched
// - remote request auto-sets request when enabled
// - loopback mode bit registered out on loopback_ff
// - bus activity wakes, optional low-pass filter
// - bit rate up to one megabit
// - error states and buffer events flagged
module cmbc_core import cmbc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic [ID_W-1:0] rx_id,
	input wire logic rx_ext,
	input wire logic rx_rtr,
	input wire logic rx_srr,
	input wire logic rx_crc_ok,
	input wire logic [3:0] rx_dlc,
	input wire logic tx_done,
	input wire logic [1:0] tx_result,
	output logic tx_start,
	output logic [3:0] tx_buf,
	output logic tx_abort,
	input wire logic bus_receive_pin,
	output logic wake_ff,
	output logic loopback_ff,
	output logic [1:0] func_mode_ff
);
	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] mode_ff; // mode register
	logic [NUM_CFG-1:0] buffer_direction_select_ff; // per buffer transmit enable
	logic [7:0] bcon_ff [NUM_BUF]; // buffer_tx_control per buffer
	logic [ID_W-1:0] filt_id_ff [NUM_FILT]; // filter identifiers
	logic [NUM_FILT-1:0] filt_ext_ff; // filter extended flags
	logic [NUM_FILT-1:0] filt_en_ff; // filter enables
	logic [1:0] filt_link_ff [NUM_FILT]; // mask link per filter
	logic [ID_W-1:0] mask_ff [2]; // two full masks
	logic [3:0] fsel_ff; // filter window index
	logic mask_sel_ff; // mask window index
	logic [7:0] sidl_ff [NUM_RXB]; // rx_std_id_low
	logic [7:0] eidh_ff [NUM_RXB]; // rx_ext_id_high
	logic [7:0] eidl_ff [NUM_RXB]; // rx_ext_id_low
	logic [NUM_RXB-1:0] rx_full_ff; // receive buffer occupied
	logic [7:0] err_ff; // sticky error and event flags
	logic busy_ff; // frame handed to engine
	logic [3:0] cur_ff; // buffer being transmitted
	logic [1:0] pin_sync_ff; // receive pin synchroniser
	logic [3:0] wcnt_ff; // wake filter counter
	logic [7:0] rdata_ff; // read data
	logic tx_start_ff; // start pulse
	logic tx_abort_ff; // abort request to engine
	////////////////////////////////////////////////////////////////////////////
	// decode helpers
	logic wr_bcon, rd_any; // buffer write strike, read
	logic [3:0] wr_idx; // buffer index of write
	logic cfg_mode; // configuration mode
	assign wr_idx = 4'(reg_addr - ADDR_BUF_CON);
	assign wr_bcon = reg_wr && reg_addr >= ADDR_BUF_CON && reg_addr < ADDR_BUF_CON + 8'(NUM_BUF);
	assign rd_any = reg_rd;
	assign cfg_mode = mode_ff[MODE_CFG];
	// buffer is in transmit layout: dedicated, or configurable with enable set
	function automatic logic is_tx(input int i, input logic [NUM_CFG-1:0] sel);
		is_tx = (i < NUM_DED) || sel[i-NUM_DED];
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// acceptance filter: hit per filter in one generate loop
	logic [NUM_FILT-1:0] hit; // matching filters
	logic [ID_W-1:0] idm; // identifier truncated for standard frames
	assign idm = rx_ext ? rx_id : {18'h0, rx_id[10:0]};
	genvar gf;
	generate
		for (gf = 0; gf < NUM_FILT; gf++) begin : g_filt
			logic [ID_W-1:0] m; // mask selected by link
			always_comb begin
				case (filt_link_ff[gf])
					2'h0: m = mask_ff[0];
					2'h1: m = mask_ff[1];
					MASK_FILT15: m = filt_id_ff[FILT_AS_MASK];
					default: m = '0;
				endcase
			end
			// filter 15 still acts as a filter while linked as a mask elsewhere
			assign hit[gf] = filt_en_ff[gf] && filt_ext_ff[gf] == rx_ext
				&& ((idm ^ filt_id_ff[gf]) & m) == '0;
		end
	endgenerate
	logic accept; // frame survives error check and filtering
	assign accept = rx_valid && rx_crc_ok && (|hit) && rx_dlc <= 4'h8;
	logic rx_slot; // receive buffer chosen: 0 first, 1 when 0 full
	assign rx_slot = rx_full_ff[0];
	////////////////////////////////////////////////////////////////////////////
	// transmit arbitration: highest priority pending buffer, lowest index on tie
	logic [3:0] pick; // selected buffer
	logic pick_ok; // any pending
	logic [2:0] best; // priority plus one of selection
	always_comb begin
		pick = '0;
		pick_ok = 1'b0;
		best = '0;
		for (int i = 0; i < NUM_BUF; i++) begin
			if (is_tx(i, buffer_direction_select_ff) && bcon_ff[i][BC_REQ]
				&& {1'b0, bcon_ff[i][1:0]} + 3'h1 > best) begin
				best = {1'b0, bcon_ff[i][1:0]} + 3'h1;
				pick = 4'(i);
				pick_ok = 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// mode, direction, window registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_ff <= MODE_RESET;
			buffer_direction_select_ff <= '0;
			fsel_ff <= '0;
			mask_sel_ff <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				ADDR_MODE: mode_ff <= reg_wdata;
				ADDR_DIR_SEL: if (cfg_mode) buffer_direction_select_ff <= reg_wdata[NUM_CFG-1:0];
				ADDR_FILT_SEL: fsel_ff <= reg_wdata[3:0];
				ADDR_MASK_SEL: mask_sel_ff <= reg_wdata[0];
				default: ;
			endcase
		end
	end
	// filters and masks, writable only in configuration mode
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			filt_en_ff <= '0;
			filt_ext_ff <= '0;
			for (int i = 0; i < NUM_FILT; i++) begin
				filt_id_ff[i] <= '0;
				filt_link_ff[i] <= '0;
			end
			mask_ff[0] <= '0;
			mask_ff[1] <= '0;
		end else if (reg_wr && cfg_mode) begin
			case (reg_addr)
				ADDR_FILT_ID0: filt_id_ff[fsel_ff][7:0] <= reg_wdata;
				ADDR_FILT_ID1: filt_id_ff[fsel_ff][15:8] <= reg_wdata;
				ADDR_FILT_ID2: filt_id_ff[fsel_ff][23:16] <= reg_wdata;
				ADDR_FILT_ID3: begin
					filt_id_ff[fsel_ff][28:24] <= reg_wdata[4:0];
					filt_ext_ff[fsel_ff] <= reg_wdata[7];
				end
				ADDR_FILT_LINK: begin
					filt_link_ff[fsel_ff] <= reg_wdata[1:0];
					filt_en_ff[fsel_ff] <= reg_wdata[7];
				end
				ADDR_MASK_ID0: mask_ff[mask_sel_ff][7:0] <= reg_wdata;
				ADDR_MASK_ID1: mask_ff[mask_sel_ff][15:8] <= reg_wdata;
				ADDR_MASK_ID2: mask_ff[mask_sel_ff][23:16] <= reg_wdata;
				ADDR_MASK_ID3: mask_ff[mask_sel_ff][28:24] <= reg_wdata[4:0];
				default: ;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// receive storage; reading sidl frees the buffer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_full_ff <= '0;
			for (int i = 0; i < NUM_RXB; i++) begin
				sidl_ff[i] <= '0;
				eidh_ff[i] <= '0;
				eidl_ff[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_RXB; i++) begin
				if (rd_any && reg_addr == ADDR_RX_SIDL + 8'(2 * i))
					rx_full_ff[i] <= 1'b0;
			end
			if (accept && !(&rx_full_ff)) begin
				rx_full_ff[rx_slot] <= 1'b1; // set wins over the read clear
				sidl_ff[rx_slot] <= rx_ext
					? {rx_id[20:18], rx_srr, 1'b1, 1'b0, rx_id[17:16]}
					: {rx_id[2:0], rx_srr, 1'b0, 3'h0};
				eidh_ff[rx_slot] <= rx_ext ? rx_id[15:8] : 8'h00;
				eidl_ff[rx_slot] <= rx_ext ? rx_id[7:0] : 8'h00;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// buffer control registers: software fields, hardware status
	logic remote_hit; // accepted remote request frame, any buffer
	assign remote_hit = accept && rx_rtr;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_BUF; i++)
				bcon_ff[i] <= '0;
		end else begin
			for (int i = 0; i < NUM_BUF; i++) begin
				if (wr_bcon && wr_idx == 4'(i) && is_tx(i, buffer_direction_select_ff)) begin
					if (reg_wdata[BC_REQ] && !bcon_ff[i][BC_REQ]) begin
						// new request: status cleared, fields taken
						bcon_ff[i] <= {1'b0, 3'h0, 1'b1, reg_wdata[2:0]};
					end else if (!reg_wdata[BC_REQ] && bcon_ff[i][BC_REQ]) begin
						bcon_ff[i][BC_REQ] <= 1'b0; // abort request
						if (!(busy_ff && cur_ff == 4'(i)) || (tx_done && cmbc_txres_t'(tx_result) != TXR_OK))
							bcon_ff[i][BC_ABT] <= 1'b1;
					end else if (!bcon_ff[i][BC_REQ]) begin
						bcon_ff[i][BC_DONE] <= reg_wdata[BC_DONE];
						bcon_ff[i][2:0] <= reg_wdata[2:0];
					end
				end
				if (remote_hit && is_tx(i, buffer_direction_select_ff) && bcon_ff[i][BC_RTR]
					&& filt_id_ff[i] == idm)
					bcon_ff[i][BC_REQ] <= 1'b1;
				if (tx_done && busy_ff && cur_ff == 4'(i)) begin
					case (cmbc_txres_t'(tx_result))
						TXR_OK: begin
							bcon_ff[i][BC_DONE] <= 1'b1;
							bcon_ff[i][BC_REQ] <= 1'b0;
							bcon_ff[i][BC_LARB] <= 1'b0;
						end
						TXR_LARB: bcon_ff[i][BC_LARB] <= 1'b1;
						TXR_ERR: bcon_ff[i][BC_ERR] <= 1'b1;
						default: ;
					endcase
					if (!bcon_ff[i][BC_REQ] && cmbc_txres_t'(tx_result) != TXR_OK)
						bcon_ff[i][BC_ABT] <= 1'b1;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// transmit sequencer hands one buffer at a time to the engine
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			cur_ff <= '0;
			tx_start_ff <= 1'b0;
			tx_abort_ff <= 1'b0;
		end else begin
			tx_start_ff <= 1'b0;
			if (!busy_ff && pick_ok && !cfg_mode && !mode_ff[MODE_SLEEP]) begin
				busy_ff <= 1'b1;
				cur_ff <= pick;
				tx_start_ff <= 1'b1;
			end else if (busy_ff && tx_done) begin
				busy_ff <= 1'b0;
			end
			tx_abort_ff <= busy_ff && !bcon_ff[cur_ff][BC_REQ] && !tx_done;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// error and event flags; set wins over write-one clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			err_ff <= '0;
		end else begin
			for (int b = 0; b < 8; b++) begin
				if (reg_wr && reg_addr == ADDR_ERR && reg_wdata[b])
					err_ff[b] <= 1'b0;
			end
			if (rx_valid && !rx_crc_ok) err_ff[0] <= 1'b1;
			if (tx_done && cmbc_txres_t'(tx_result) == TXR_ERR) err_ff[1] <= 1'b1;
			if (accept && (&rx_full_ff)) err_ff[2] <= 1'b1;
			if (accept && !(&rx_full_ff)) err_ff[3] <= 1'b1;
			if (tx_done && cmbc_txres_t'(tx_result) == TXR_OK) err_ff[4] <= 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// wake detector: synchronised pin, optional low-pass count
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_sync_ff <= 2'h3;
			wcnt_ff <= '0;
			wake_ff <= 1'b0;
		end else begin
			pin_sync_ff <= {pin_sync_ff[0], bus_receive_pin};
			if (!mode_ff[MODE_SLEEP]) begin
				wcnt_ff <= '0;
				wake_ff <= 1'b0;
			end else if (!pin_sync_ff[1]) begin
				if (wcnt_ff != WAKE_FILT_LEN) wcnt_ff <= wcnt_ff + 4'h1;
				if (!mode_ff[MODE_WFILT] || wcnt_ff == WAKE_FILT_LEN)
					wake_ff <= 1'b1;
			end else begin
				wcnt_ff <= '0;
			end
		end
	end
	// mode outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			loopback_ff <= 1'b0;
			func_mode_ff <= FMODE_LEGACY;
		end else begin
			loopback_ff <= mode_ff[MODE_LOOP];
			func_mode_ff <= (mode_ff[1:0] == FMODE_FIFO || mode_ff[1:0] == FMODE_ENH)
				? mode_ff[1:0] : FMODE_LEGACY;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// read mux, data valid the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= DATA_ZERO;
			if (reg_rd) begin
				if (reg_addr == ADDR_MODE) rdata_ff <= mode_ff;
				if (reg_addr == ADDR_DIR_SEL) rdata_ff <= 8'(buffer_direction_select_ff);
				if (reg_addr == ADDR_STATUS) rdata_ff <= {busy_ff, wake_ff, 4'(rx_full_ff), mode_ff[1:0]};
				if (reg_addr == ADDR_ERR) rdata_ff <= err_ff;
				for (int i = 0; i < NUM_RXB; i++) begin
					if (reg_addr == ADDR_RX_SIDL + 8'(2 * i)) rdata_ff <= sidl_ff[i];
					if (reg_addr == ADDR_RX_EIDH + 8'(2 * i)) rdata_ff <= eidh_ff[i];
					if (reg_addr == ADDR_RX_EIDL + 8'(2 * i)) rdata_ff <= eidl_ff[i];
				end
				for (int i = 0; i < NUM_BUF; i++)
					if (reg_addr == ADDR_BUF_CON + 8'(i)) rdata_ff <= bcon_ff[i];
			end
		end
	end
	assign reg_rdata = rdata_ff;
	assign tx_start = tx_start_ff;
	assign tx_buf = cur_ff;
	assign tx_abort = tx_abort_ff;
	////////////////////////////////////////////////////////////////////////////
	// assertions
	a_done_clears_req: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_done && busy_ff && cmbc_txres_t'(tx_result) == TXR_OK |=> !bcon_ff[cur_ff][BC_REQ])
		else $error("request not cleared after success");
	a_start_one_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_start_ff |=> !tx_start_ff)
		else $error("start not single pulse");
	a_larb_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
		tx_done && busy_ff && cmbc_txres_t'(tx_result) == TXR_LARB |=> bcon_ff[cur_ff][BC_LARB])
		else $error("lost arbitration not flagged");
	a_rx_stores: assert property (@(posedge core_clk) disable iff (!rst_n)
		accept && rx_full_ff == 2'h0 |=> rx_full_ff[0])
		else $error("accepted frame not stored");
	a_loop_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> loopback_ff == $past(mode_ff[MODE_LOOP]))
		else $error("loopback mismatch");
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == DATA_ZERO)
		else $error("read data outside read");
endmodule // cmbc_core

/* verification/cmbc_engine_model.sv */
// partner model: protocol engine that sends queued frames and reports a commanded result
module cmbc_engine_model import cmbc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tx_start,
	input wire logic tx_abort,
	input wire logic [1:0] res_cmd,
	input wire logic [7:0] dly_cmd,
	output logic tx_done,
	output logic [1:0] tx_result
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_ff; // cycles left of the frame on the wire, 0 when idle
	//////////////////////////////////////////////////////////////////////////////
	// frame timer: an abort cuts the frame short and reports no result
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff <= 0;
			tx_done <= 1'b0;
			tx_result <= 2'h0;
		end else begin
			tx_done <= 1'b0;
			tx_result <= ~tx_result; // code is junk outside the answer cycle
			if (tx_start) begin
				cnt_ff <= int'(dly_cmd);
			end else if (cnt_ff == 1 || (cnt_ff > 1 && tx_abort)) begin
				tx_done <= 1'b1;
				tx_result <= tx_abort ? 2'h0 : res_cmd;
				cnt_ff <= 0;
			end else if (cnt_ff > 1) begin
				cnt_ff <= cnt_ff - 1;
			end
		end
	end
endmodule // cmbc_engine_model

/* verification/tb_cmbc_core.sv */
// testbench: register, filter, receive and transmit scenarios of the buffer control core
module tb_cmbc_core import cmbc_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk, rst_n, reg_wr, reg_rd, rx_valid, rx_ext, rx_rtr, rx_srr, rx_crc_ok;
	logic tx_done, tx_start, tx_abort, bus_receive_pin, wake_ff, loopback_ff;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, dly_cmd, rv;
	logic [ID_W-1:0] rx_id;
	logic [3:0] rx_dlc, tx_buf, b;
	logic [1:0] tx_result, func_mode_ff, res_cmd;
	bit got;
	int error_cnt = 0;
	int compares = 0;
	localparam logic [ID_W-1:0] ID_R0 = 29'h0000_0123; // remote reply id, filter 0
	localparam logic [ID_W-1:0] ID_R1 = 29'h0000_0456; // filter 1
	localparam logic [ID_W-1:0] ID_X = 29'h15A5_C3E7; // extended id, filter 2
	cmbc_core u_cmbc_core (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_valid, .rx_id, .rx_ext, .rx_rtr, .rx_srr, .rx_crc_ok, .rx_dlc, .tx_done, .tx_result,
		.tx_start, .tx_buf, .tx_abort, .bus_receive_pin, .wake_ff, .loopback_ff, .func_mode_ff);
	cmbc_engine_model u_cmbc_engine_model (.core_clk, .rst_n, .tx_start, .tx_abort, .res_cmd, .dly_cmd,
		.tx_done, .tx_result);
	//////////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		finish_test();
	end
	//////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata; // data stand only in this cycle
	endtask
	task automatic wait_tx(input int lim);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge core_clk);
			#1 got = (tx_start === 1'b1);
			b = tx_buf;
		end
	endtask
	task automatic frame(input logic [ID_W-1:0] id, input logic ext, input logic rtr, input logic ok);
		@(posedge core_clk);
		{rx_id, rx_ext, rx_rtr, rx_srr, rx_crc_ok, rx_dlc} <= {id, ext, rtr, ext, ok, 4'h8};
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_valid <= 1'b0;
	endtask
	task automatic set_filt(input logic [3:0] n, input logic [ID_W-1:0] id, input logic ext);
		wr(ADDR_FILT_SEL, {4'h0, n});
		wr(ADDR_FILT_ID0, id[7:0]);
		wr(ADDR_FILT_ID1, id[15:8]);
		wr(ADDR_FILT_ID2, id[23:16]);
		wr(ADDR_FILT_ID3, {ext, 2'h0, id[28:24]});
		wr(ADDR_FILT_LINK, 8'h80); // enabled, linked to full mask 0
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset_modes();
		rd(ADDR_MODE);
		chk(rv, MODE_RESET);
		rd(8'hF0); // unmapped
		chk(rv, DATA_ZERO);
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_MODE, 8'h10 | 8'(m) | ((m == 1) ? 8'h20 : 8'h00));
			rd(ADDR_MODE);
			chk(func_mode_ff, m);
			chk(loopback_ff, m == 1);
		end
		wr(ADDR_MODE, 8'h11); // enhanced, still in configuration
	endtask
	task automatic t_setup();
		for (int k = 0; k < 4; k++) wr(ADDR_MASK_ID0 + 8'(k), (k == 3) ? 8'h1F : 8'hFF);
		set_filt(4'h0, ID_R0, 1'b0);
		set_filt(4'h1, ID_R1, 1'b0);
		set_filt(4'h2, ID_X, 1'b1);
		wr(ADDR_DIR_SEL, 8'h01); // first configurable buffer transmits
		wr(ADDR_BUF_CON + 8'h4, 8'h03);
		rd(ADDR_BUF_CON + 8'h4);
		chk(rv & 8'h0B, 8'h00);
		wr(ADDR_BUF_CON + 8'h3, 8'h06);
		rd(ADDR_BUF_CON + 8'h3);
		chk(rv, 8'h06);
	endtask
	task automatic t_priority();
		wr(ADDR_BUF_CON + 8'h0, 8'h09);
		wr(ADDR_BUF_CON + 8'h1, 8'h0B);
		wr(ADDR_BUF_CON + 8'h2, 8'h0A);
		wr(ADDR_MODE, 8'h01); // leave configuration: queue starts
		for (int i = 0; i < 3; i++) begin
			wait_tx(200);
			chk({got, b}, {1'b1, 4'((i == 0) ? 1 : (i == 1) ? 2 : 0)});
		end
		repeat (30) @(posedge core_clk);
		rd(ADDR_BUF_CON + 8'h1);
		chk(rv, 8'h83);
	endtask
	task automatic t_lock();
		dly_cmd <= 8'd40;
		wr(ADDR_BUF_CON + 8'h0, 8'h08);
		wait_tx(50);
		wr(ADDR_BUF_CON + 8'h0, 8'h0B); // refused while pending
		repeat (60) @(posedge core_clk);
		rd(ADDR_BUF_CON + 8'h0);
		chk(rv, 8'h80);
	endtask
	task automatic t_fail_paths();
		res_cmd <= 2'h2;
		dly_cmd <= 8'd5;
		wr(ADDR_BUF_CON + 8'h2, 8'h08);
		wait_tx(50);
		repeat (10) @(posedge core_clk);
		rd(ADDR_BUF_CON + 8'h2);
		chk(rv[BC_LARB], 1'b1);
		wr(ADDR_BUF_CON + 8'h2, 8'h00); // abort
		repeat (30) @(posedge core_clk);
		rd(ADDR_BUF_CON + 8'h2);
		chk({rv[BC_ABT], rv[BC_REQ]}, 2'b10);
		res_cmd <= 2'h3;
		dly_cmd <= 8'd30;
		wr(ADDR_BUF_CON + 8'h2, 8'h08);
		rd(ADDR_BUF_CON + 8'h2);
		chk({rv[BC_ABT], rv[BC_LARB]}, 2'b00);
		repeat (40) @(posedge core_clk);
		rd(ADDR_BUF_CON + 8'h2);
		chk(rv[BC_ERR], 1'b1);
		wr(ADDR_BUF_CON + 8'h2, 8'h00);
		@(posedge core_clk);
		#1 chk(tx_abort, 1'b1);
		res_cmd <= 2'h1;
		dly_cmd <= 8'd5;
		repeat (40) @(posedge core_clk);
	endtask
	task automatic t_receive();
		wr(ADDR_ERR, 8'hFF);
		frame(ID_X, 1'b1, 1'b0, 1'b1);
		rd(ADDR_ERR);
		chk(rv[3], 1'b1);
		rd(ADDR_RX_EIDH);
		chk(rv, ID_X[15:8]);
		rd(ADDR_RX_EIDL);
		chk(rv, ID_X[7:0]);
		rd(ADDR_RX_SIDL);
		chk(rv & 8'hF8, {ID_X[20:18], 5'b11000});
		wr(ADDR_ERR, 8'hFF);
		frame(ID_X, 1'b1, 1'b0, 1'b0);
		frame(29'h0000_0777, 1'b0, 1'b0, 1'b1);
		rd(ADDR_ERR);
		chk({rv[3], rv[0]}, 2'b01);
	endtask
	task automatic t_remote_wake();
		wr(ADDR_BUF_CON + 8'h0, 8'h04);
		wr(ADDR_BUF_CON + 8'h1, 8'h00);
		frame(ID_R0, 1'b0, 1'b1, 1'b1);
		wait_tx(30);
		chk({got, b}, 5'h10);
		repeat (20) @(posedge core_clk);
		frame(ID_R1, 1'b0, 1'b1, 1'b1);
		wait_tx(30);
		chk(got, 1'b0);
		wr(ADDR_MODE, 8'hC1);
		bus_receive_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		bus_receive_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk(wake_ff, 1'b0);
		bus_receive_pin <= 1'b0;
		repeat (16) @(posedge core_clk);
		chk(wake_ff, 1'b1);
		bus_receive_pin <= 1'b1;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, rx_valid, rx_ext, rx_rtr, rx_srr, rx_crc_ok} = '0;
		{reg_addr, reg_wdata, rx_id, rx_dlc} = '0;
		bus_receive_pin = 1'b1;
		res_cmd = 2'h1;
		dly_cmd = 8'd20;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset_modes();
		t_setup();
		t_priority();
		t_lock();
		t_fail_paths();
		t_receive();
		t_remote_wake();
		finish_test();
	end
endmodule // tb_cmbc_core
